//--- rtl/spisc_top.sv
// Serial peripheral port with slave-select handling, APB registers and interrupt.
// Assumes pin inputs synchronous to core_clk and a pad ring that resolves enables.
//
// Contract
// - Slave mode keeps select pin an input.
// - Selected slave drives data-out only if configured.
// - Deselected slave: all pins inputs, ignores data.
// - Select rise resets counter, drops partial byte.
// - Master select output is plain GPIO.
// - Select low in master, with select an input, forces slave mode.
// - Forced slave sets done flag, may interrupt.
// - Enable bit plus global enable request interrupt.
// - No serial operation unless port enabled.
// - Bit-order control picks LSB or MSB first.
// - Polarity sets idle level, phase sample edge.
// - Rate bits and double bit divide master clock.
//
// The APB register port was decided locally.
`timescale 1ns/10ps
`include "spisc_params.svh"

module spisc_top (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial pins
   input wire logic mosiIn,
   input wire logic misoIn,
   input wire logic sckIn,
   input wire logic ssIn,
   output spisc_pkg::spisc_pins_t pins,
   // Interrupt
   output logic irq
);
   import spisc_pkg::*;

   // ************************************************************
   // Helpers
   // ************************************************************

   // Half period of the master clock from double and rate bits
   function automatic logic [5:0] halfOf(input logic [2:0] sel);
      logic [5:0] h;
      h = `SPISC_HALF_0;
      unique case (sel)
         3'h0: h = `SPISC_HALF_0;
         3'h1: h = `SPISC_HALF_1;
         3'h2: h = `SPISC_HALF_2;
         3'h3: h = `SPISC_HALF_3;
         3'h4: h = `SPISC_HALF_4;
         3'h5: h = `SPISC_HALF_5;
         3'h6: h = `SPISC_HALF_6;
         3'h7: h = `SPISC_HALF_7;
      endcase
      return h;
   endfunction

   // Shift one bit in at the end that leaves last
   function automatic logic [7:0] shiftIn(input logic [7:0] s, input logic b, input logic lsb);
      return lsb ? {b, s[7:1]} : {s[6:0], b};
   endfunction

   spisc_state_t r;
   spisc_state_t n;

   // Decoded control bits of the current state
   logic en, master_select_bit, lsb, clock_idle_polarity, clock_sample_phase;
   logic ssIsIn, fault, setup, access, wrEn, rdEn;
   logic sckRise, sckFall, slvSample, txBit;
   logic [5:0] half;

   // Bit-order, polarity, phase and rate selection
   assign en = r.ctrl[`SPISC_CTRL_EN];
   assign master_select_bit = r.ctrl[`SPISC_CTRL_MASTER_SELECT_BIT];
   assign lsb = r.ctrl[`SPISC_CTRL_LSB];
   assign clock_idle_polarity = r.ctrl[`SPISC_CTRL_CLOCK_IDLE_POLARITY];
   assign clock_sample_phase = r.ctrl[`SPISC_CTRL_CLOCK_SAMPLE_PHASE];
   assign half = halfOf({r.dbl, r.ctrl[1:0]});
   assign txBit = lsb ? r.shift[0] : r.shift[7];
   assign ssIsIn = !r.pinCfg[`SPISC_PIN_SS];

   // Another master pulls our select low while we are master
   assign fault = en && master_select_bit && ssIsIn && !ssIn;

   // Slave edge detection on the sampled clock pin
   assign sckRise = sckIn && !r.sckPrev;
   assign sckFall = !sckIn && r.sckPrev;
   assign slvSample = clock_sample_phase ? (clock_idle_polarity ? sckRise : sckFall) : (clock_idle_polarity ? sckFall : sckRise);

   // APB phases; one wait-free access cycle after setup
   assign setup = psel && !penable;
   assign access = psel && penable && r.pready;
   assign wrEn = access && pwrite;
   assign rdEn = access && !pwrite;

   // ************************************************************
   // Next state
   // ************************************************************

   // All register, shifter, sequencer and pin logic in one pass
   always_comb begin
      logic [7:0] rdv;
      logic hit;
      logic doneSet;
      logic outHold;
      rdv = 8'h00;
      hit = 1'b1;
      doneSet = 1'b0;
      outHold = 1'b0;
      n = r;
      n.sckPrev = sckIn;
      n.ssPrev = ssIn;

      // Register writes take effect at the accepted access edge
      if (wrEn) begin
         unique case (paddr)
            `SPISC_OFS_CTRL: n.ctrl = pwdata[7:0];
            `SPISC_OFS_STAT: n.dbl = pwdata[`SPISC_STAT_DBL];
            `SPISC_OFS_PINS: n.pinCfg = pwdata[7:0];
            `SPISC_OFS_ISTAT: n.iStat = r.iStat & ~pwdata[1:0];
            `SPISC_OFS_IMASK: n.iMask = pwdata[1:0];
            `SPISC_OFS_GIE: n.gie = pwdata[0];
            `SPISC_OFS_DATA: begin
               n.txHold = pwdata[7:0];
               // Master start only when idle; a busy write only updates the holding byte
               if (en && master_select_bit && r.mst == SPISC_IDLE) begin
                  n.shift = pwdata[7:0];
                  n.mst = SPISC_RUN;
                  n.divCnt = 6'h00;
                  n.edgeCnt = 4'h0;
                  n.bitCnt = 3'h0;
               end else if (!master_select_bit && (ssIn || r.bitCnt == 3'h0)) begin
                  n.shift = pwdata[7:0];
               end
            end
            default: ;
         endcase
      end

      // Status read arms the flag clear; the next data access clears it
      if (rdEn && paddr == `SPISC_OFS_STAT && r.done) begin
         n.armed = 1'b1;
      end
      if (access && paddr == `SPISC_OFS_DATA && r.armed) begin
         n.done = 1'b0;
         n.armed = 1'b0;
      end

      // Master clock generator and shifter
      if (!en) begin
         n.mst = SPISC_IDLE;
         n.sckGen = 1'b0;
         n.bitCnt = 3'h0;
      end else if (r.mst == SPISC_RUN) begin
         if (r.divCnt == half - 6'h01) begin
            n.divCnt = 6'h00;
            n.sckGen = !r.sckGen;
            // Even edges lead, odd edges trail
            if (r.edgeCnt[0] == clock_sample_phase) begin
               n.shift = shiftIn(n.shift, misoIn, lsb);
               n.bitCnt = r.bitCnt + 3'h1;
               outHold = 1'b1;
            end
            if (r.edgeCnt == `SPISC_LAST_EDGE) begin
               n.mst = SPISC_IDLE;
               n.rxBuf = n.shift;
               doneSet = 1'b1;
            end else begin
               n.edgeCnt = r.edgeCnt + 4'h1;
            end
         end else begin
            n.divCnt = r.divCnt + 6'h01;
         end
      end

      // Slave shifter, only while selected
      if (en && !master_select_bit) begin
         if (ssIn && !r.ssPrev) begin
            n.bitCnt = 3'h0;
            n.shift = r.txHold;
         end else if (!ssIn && slvSample) begin
            n.shift = shiftIn(r.shift, mosiIn, lsb);
            n.bitCnt = r.bitCnt + 3'h1;
            outHold = 1'b1;
            if (r.bitCnt == 3'h7) begin
               n.rxBuf = shiftIn(r.shift, mosiIn, lsb);
               n.shift = r.txHold;
               doneSet = 1'b1;
            end
         end
      end

      // Mode fault: drop to slave, stop the clock, lose the byte
      if (fault) begin
         n.ctrl[`SPISC_CTRL_MASTER_SELECT_BIT] = 1'b0;
         n.mst = SPISC_IDLE;
         n.sckGen = 1'b0;
         n.bitCnt = 3'h0;
         n.shift = r.txHold;
         n.iStat[`SPISC_EVT_FAULT] = 1'b1;
         doneSet = 1'b1;
      end

      // Hardware set wins over any clear in the same cycle
      if (doneSet) begin
         n.done = 1'b1;
         n.iStat[`SPISC_EVT_DONE] = 1'b1;
      end

      // Interrupt: done flag with interrupt enable bit and global enable, plus masked sticky events
      n.irq = (n.gie && n.ctrl[`SPISC_CTRL_IRQEN] && n.done) || |(n.iStat & n.iMask);

      // Pin directions follow the mode of the next state
      n.pins.ssOut = n.pinCfg[`SPISC_PIN_OUT + `SPISC_PIN_SS];
      n.pins.mosiOut = n.pinCfg[`SPISC_PIN_OUT + `SPISC_PIN_MOSI];
      n.pins.misoOut = n.pinCfg[`SPISC_PIN_OUT + `SPISC_PIN_MISO];
      n.pins.sckOut = n.pinCfg[`SPISC_PIN_OUT + `SPISC_PIN_SCK];
      n.pins.mosiOe = n.pinCfg[`SPISC_PIN_MOSI];
      n.pins.misoOe = n.pinCfg[`SPISC_PIN_MISO];
      n.pins.sckOe = n.pinCfg[`SPISC_PIN_SCK];
      n.pins.ssOe = n.pinCfg[`SPISC_PIN_SS];
      if (n.ctrl[`SPISC_CTRL_EN] && n.ctrl[`SPISC_CTRL_MASTER_SELECT_BIT]) begin
         // Select stays general purpose in master mode
         n.pins.ssOe = n.pinCfg[`SPISC_PIN_SS];
         n.pins.misoOe = 1'b0;
         // Out bit holds through a sample edge so the partner never samples it mid-change
         n.pins.mosiOut = outHold ? r.pins.mosiOut : (n.ctrl[`SPISC_CTRL_LSB] ? n.shift[0] : n.shift[7]);
         n.pins.sckOut = n.ctrl[`SPISC_CTRL_CLOCK_IDLE_POLARITY] ^ n.sckGen;
      end else if (n.ctrl[`SPISC_CTRL_EN]) begin
         n.pins.ssOe = 1'b0;
         n.pins.mosiOe = 1'b0;
         n.pins.sckOe = 1'b0;
         n.pins.misoOe = !ssIn && n.pinCfg[`SPISC_PIN_MISO];
         n.pins.misoOut = outHold ? r.pins.misoOut : (n.ctrl[`SPISC_CTRL_LSB] ? n.shift[0] : n.shift[7]);
      end

      // Read data is prepared during setup so it is valid in the access cycle
      unique case (paddr)
         `SPISC_OFS_CTRL: rdv = r.ctrl;
         `SPISC_OFS_STAT: rdv = {r.done, 6'h00, r.dbl};
         `SPISC_OFS_DATA: rdv = r.rxBuf;
         `SPISC_OFS_PINS: rdv = r.pinCfg;
         `SPISC_OFS_ISTAT: rdv = {6'h00, r.iStat};
         `SPISC_OFS_IMASK: rdv = {6'h00, r.iMask};
         `SPISC_OFS_GIE: rdv = {7'h00, r.gie};
         default: hit = 1'b0;
      endcase
      n.pready = setup;
      n.pslverr = setup && !hit;
      n.prdata = setup ? {24'h000000, rdv} : 32'h00000000;
   end

   // ************************************************************
   // State register
   // ************************************************************

   // Single state flop; outputs come straight from it
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
         r.ctrl <= `SPISC_RST_CTRL;
         r.pinCfg <= `SPISC_RST_PINS;
         r.mst <= SPISC_IDLE;
         // Select idles high; a low start value would fake a rise
         r.ssPrev <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign pins = r.pins;
   assign irq = r.irq;

   // ************************************************************
   // Assertions
   // ************************************************************

   sequence s_fault;
      en && master_select_bit && ssIsIn && !ssIn;
   endsequence

   sequence s_slaveSel;
      en && !master_select_bit && !ssIn;
   endsequence

   property p_ssInput;
      @(posedge core_clk) disable iff (!arst_n) (en && !master_select_bit) |-> !pins.ssOe;
   endproperty
   a_ssInput: assert property (p_ssInput) else $error("select driven in slave mode");

   property p_misoDrive;
      @(posedge core_clk) disable iff (!arst_n)
         ($past(en) && !$past(master_select_bit) && en && !master_select_bit) |-> (pins.misoOe == (!$past(ssIn) && r.pinCfg[1]));
   endproperty
   a_misoDrive: assert property (p_misoDrive) else $error("data-out enable wrong in slave");

   property p_passive;
      @(posedge core_clk) disable iff (!arst_n)
         (en && !master_select_bit && ssIn && !$rose(ssIn)) |=> (r.bitCnt == $past(r.bitCnt));
   endproperty
   a_passive: assert property (p_passive) else $error("deselected slave shifted");

   property p_ssRise;
      @(posedge core_clk) disable iff (!arst_n) (en && !master_select_bit && ssIn && !r.ssPrev) |=> r.bitCnt == 3'h0;
   endproperty
   a_ssRise: assert property (p_ssRise) else $error("bit counter not reset on select rise");

   property p_faultSlave;
      @(posedge core_clk) disable iff (!arst_n) s_fault |=> (!master_select_bit && r.done);
   endproperty
   a_faultSlave: assert property (p_faultSlave) else $error("fault did not force slave");

   property p_faultIrq;
      @(posedge core_clk) disable iff (!arst_n) (s_fault ##1 (r.gie && r.ctrl[7])) |=> irq;
   endproperty
   a_faultIrq: assert property (p_faultIrq) else $error("fault gave no interrupt");

   property p_irqEn;
      @(posedge core_clk) disable iff (!arst_n) (r.gie && r.ctrl[7] && r.done) |-> irq;
   endproperty
   a_irqEn: assert property (p_irqEn) else $error("enabled done flag without interrupt");

   property p_disabled;
      @(posedge core_clk) disable iff (!arst_n) !en |=> (r.mst == SPISC_IDLE && r.bitCnt == 3'h0);
   endproperty
   a_disabled: assert property (p_disabled) else $error("activity while disabled");

   property p_idleClk;
      @(posedge core_clk) disable iff (!arst_n) (en && master_select_bit && r.mst == SPISC_IDLE) |-> pins.sckOut == clock_idle_polarity;
   endproperty
   a_idleClk: assert property (p_idleClk) else $error("master clock not at idle level");

   property p_abandon;
      @(posedge core_clk) disable iff (!arst_n) (s_fault ##0 (r.mst == SPISC_RUN)) |=> r.mst == SPISC_IDLE;
   endproperty
   a_abandon: assert property (p_abandon) else $error("transfer survived fault");

   property p_slvCount;
      @(posedge core_clk) disable iff (!arst_n)
         (s_slaveSel ##0 slvSample ##0 (r.bitCnt == 3'h7)) |=> r.done;
   endproperty
   a_slvCount: assert property (p_slvCount) else $error("slave byte end missed done");

endmodule

//--- rtl/spisc_params.svh
// Offsets, field positions, reset values and divider counts of the serial port.
// Assumes inclusion by bare name from the package, the top module and the bench.
`ifndef SPISC_PARAMS_SVH
`define SPISC_PARAMS_SVH

// Register byte addresses on the APB
`define SPISC_OFS_CTRL 12'h02C
`define SPISC_OFS_STAT 12'h030
`define SPISC_OFS_DATA 12'h034
`define SPISC_OFS_PINS 12'h038
`define SPISC_OFS_ISTAT 12'h03C
`define SPISC_OFS_IMASK 12'h040
`define SPISC_OFS_GIE 12'h044

// Control register fields
`define SPISC_CTRL_IRQEN 7
`define SPISC_CTRL_EN 6
`define SPISC_CTRL_LSB 5
`define SPISC_CTRL_MASTER_SELECT_BIT 4
`define SPISC_CTRL_CLOCK_IDLE_POLARITY 3
`define SPISC_CTRL_CLOCK_SAMPLE_PHASE 2

// Status register fields
`define SPISC_STAT_DONE 7
`define SPISC_STAT_DBL 0

// Pin register fields: direction bits 3..0, output values 7..4
`define SPISC_PIN_MOSI 0
`define SPISC_PIN_MISO 1
`define SPISC_PIN_SCK 2
`define SPISC_PIN_SS 3
`define SPISC_PIN_OUT 4

// Event bits of the interrupt status and mask registers
`define SPISC_EVT_DONE 0
`define SPISC_EVT_FAULT 1

// Reset values
`define SPISC_RST_CTRL 8'h00
`define SPISC_RST_PINS 8'h00

// Half periods of the master clock in system cycles, per {double, rate}
`define SPISC_HALF_0 6'h02
`define SPISC_HALF_1 6'h08
`define SPISC_HALF_2 6'h20
`define SPISC_HALF_3 6'h40
`define SPISC_HALF_4 6'h01
`define SPISC_HALF_5 6'h04
`define SPISC_HALF_6 6'h10
`define SPISC_HALF_7 6'h20

// Index of the last clock edge in one byte
`define SPISC_LAST_EDGE 4'hF

`endif

//--- rtl/spisc_pkg.sv
// Types of the serial port: master sequencer states and the module state.
// Assumes the params header sits on the include path.
package spisc_pkg;
   `include "spisc_params.svh"

   // One-hot master sequencer
   typedef enum logic [1:0] {
      SPISC_IDLE = 2'b01,
      SPISC_RUN = 2'b10
   } spisc_mst_t;

   // Pin outputs with enables
   typedef struct packed {
      logic mosiOut;
      logic mosiOe;
      logic misoOut;
      logic misoOe;
      logic sckOut;
      logic sckOe;
      logic ssOut;
      logic ssOe;
   } spisc_pins_t;

   // Whole state of the top module
   typedef struct packed {
      logic [7:0] ctrl;
      logic dbl;
      logic done;
      logic armed;
      logic [7:0] pinCfg;
      logic [1:0] iStat;
      logic [1:0] iMask;
      logic gie;
      logic [7:0] txHold;
      logic [7:0] shift;
      logic [7:0] rxBuf;
      logic [2:0] bitCnt;
      logic [3:0] edgeCnt;
      logic [5:0] divCnt;
      logic sckGen;
      spisc_mst_t mst;
      logic sckPrev;
      logic ssPrev;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic irq;
      spisc_pins_t pins;
   } spisc_state_t;
endpackage

//--- verif/spisc_far_model.sv
// Far side of the serial pins: a bus master for slave tests, a mode 0 slave for master tests.
// Assumes pin inputs of the port sampled on core_clk and mode 0 framing.
`timescale 1ns/10ps
module spisc_far_model (
   // Clock
   input wire logic core_clk,
   // Port pins seen from outside
   input spisc_pkg::spisc_pins_t pins,
   output logic mosiIn,
   output logic misoIn,
   output logic sckIn,
   output logic ssIn
);
   import spisc_pkg::*;
   logic [7:0] slvTx = 8'h36;
   logic [7:0] slvRx = 8'h00;
   logic [7:0] mstRx = 8'h00;
   logic [2:0] slvCnt = 3'h0;
   logic sckSeen = 1'b0;
   logic idlePat = 1'b0;
   // Select stays high unless a scenario asks otherwise
   initial begin
      ssIn = 1'b1;
      sckIn = 1'b0;
      mosiIn = 1'b0;
   end
   // Released data line toggles so no stale level passes for data
   assign misoIn = pins.sckOe ? slvTx[3'h7 - slvCnt] : idlePat;
   // Slave half: capture on rising, advance on falling
   always_ff @(posedge core_clk) begin
      sckSeen <= pins.sckOut;
      idlePat <= ~idlePat;
      if (!pins.sckOe) begin
         slvCnt <= 3'h0;
      end else if (pins.sckOut && !sckSeen) begin
         // An undriven data line reads as the inverse of the last bit
         slvRx <= {slvRx[6:0], pins.mosiOe ? pins.mosiOut : ~slvRx[0]};
      end else if (!pins.sckOut && sckSeen) begin
         slvCnt <= slvCnt + 3'h1;
      end
   end
   // Master half: clock phases of four system cycles, above the two-cycle minimum
   task automatic xfer(input logic [7:0] tx, input int nb, input logic sel);
      int i;
      @(posedge core_clk);
      ssIn <= ~sel;
      repeat (4) @(posedge core_clk);
      for (i = 0; i < nb; i++) begin
         mosiIn <= tx[7 - i];
         repeat (4) @(posedge core_clk);
         sckIn <= 1'b1;
         repeat (2) @(posedge core_clk);
         mstRx <= {mstRx[6:0], pins.misoOe ? pins.misoOut : ~mstRx[0]};
         repeat (2) @(posedge core_clk);
         sckIn <= 1'b0;
      end
      repeat (4) @(posedge core_clk);
      ssIn <= 1'b1;
      mosiIn <= ~mosiIn;
   endtask
   // Select driven by a scenario
   task automatic set_ss(input logic v);
      @(posedge core_clk);
      ssIn <= v;
   endtask
endmodule

//--- verif/tb.sv
// Self-checking bench of the serial port: register table, master, fault and slave cases.
// Assumes the far-side model and the params header on the include path.
`timescale 1ns/10ps
`include "spisc_params.svh"
module tb;
   import spisc_pkg::*;
   typedef struct packed {logic [11:0] a; logic [7:0] wd; logic [7:0] rd; logic err;} spisc_row_t;
   // Write value, read-back value, error response
   localparam spisc_row_t ROWS [0:10] = '{
      '{`SPISC_OFS_CTRL, 8'h5A, 8'h5A, 1'b0}, '{`SPISC_OFS_CTRL, 8'h00, 8'h00, 1'b0},
      '{`SPISC_OFS_STAT, 8'h81, 8'h01, 1'b0}, '{`SPISC_OFS_STAT, 8'h00, 8'h00, 1'b0},
      '{`SPISC_OFS_PINS, 8'hF5, 8'hF5, 1'b0}, '{`SPISC_OFS_PINS, 8'h00, 8'h00, 1'b0},
      '{`SPISC_OFS_IMASK, 8'h03, 8'h03, 1'b0}, '{`SPISC_OFS_IMASK, 8'h00, 8'h00, 1'b0},
      '{`SPISC_OFS_GIE, 8'h03, 8'h01, 1'b0}, '{`SPISC_OFS_GIE, 8'h00, 8'h00, 1'b0},
      '{12'h100, 8'hFF, 8'h00, 1'b1}};
   logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic mosiIn, misoIn, sckIn, ssIn;
   spisc_pins_t pins;
   int failures, n_tests, i, n;
   spisc_top dut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mosiIn(mosiIn),
      .misoIn(misoIn), .sckIn(sckIn), .ssIn(ssIn), .pins(pins), .irq(irq));
   spisc_far_model far (.core_clk(core_clk), .pins(pins), .mosiIn(mosiIn), .misoIn(misoIn), .sckIn(sckIn),
      .ssIn(ssIn));
   // Compare tasks
   task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task chk1(input string nm, input logic e, input logic g);
      chk8(nm, {7'h0, e}, {7'h0, g});
   endtask
   // One APB transfer; entered just after a rising edge, waits for pready with a bound
   task apb(input logic [11:0] a, input logic w, input logic [7:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= {24'h000000, d};
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      // A missing ready counts as a mismatch
      if (pready !== 1'b1) failures++;
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   // Poll the done flag; the status read also arms the flag clear
   task wait_done;
      n = 0;
      do begin
         apb(`SPISC_OFS_STAT, 1'b0, 8'h00);
         n++;
      end while (rdat[7] !== 1'b1 && n < 100);
      chk1("done", 1'b1, rdat[7]);
   endtask
   task print_verdict;
      $display("failures=%0d n_tests=%0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Watchdog well beyond the expected run
   initial begin
      #400000;
      failures++;
      print_verdict();
   end
   initial begin
      {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      failures = 0;
      n_tests = 0;
      repeat (10) @(posedge core_clk);
      chk8("pinsInReset", 8'h00, pins);
      arst_n <= 1'b1;
      @(posedge core_clk);
      apb(`SPISC_OFS_CTRL, 1'b0, 8'h00);
      chk8("ctrlReset", 8'h00, rdat[7:0]);
      // Register table rows
      for (i = 0; i < 11; i++) begin
         apb(ROWS[i].a, 1'b1, ROWS[i].wd);
         apb(ROWS[i].a, 1'b0, 8'h00);
         chk8("rowRead", ROWS[i].rd, rdat[7:0]);
         chk1("rowErr", ROWS[i].err, rerr);
      end
      // Master byte, MSB first, with interrupt
      apb(`SPISC_OFS_PINS, 1'b1, 8'h05);
      apb(`SPISC_OFS_GIE, 1'b1, 8'h01);
      apb(`SPISC_OFS_CTRL, 1'b1, 8'hD0);
      chk1("sckIdleLow", 1'b0, pins.sckOut);
      apb(`SPISC_OFS_DATA, 1'b1, 8'hA5);
      n = 0;
      while (irq !== 1'b1 && n < 200) begin
         @(posedge core_clk);
         n++;
      end
      chk1("irqDone", 1'b1, irq);
      chk8("mosiMsb", 8'hA5, far.slvRx);
      apb(`SPISC_OFS_STAT, 1'b0, 8'h00);
      chk8("status", 8'h80, rdat[7:0]);
      apb(`SPISC_OFS_DATA, 1'b0, 8'h00);
      chk8("rxMsb", 8'h36, rdat[7:0]);
      @(posedge core_clk);
      chk1("irqCleared", 1'b0, irq);
      // LSB first at rate 1: half period of eight cycles
      apb(`SPISC_OFS_CTRL, 1'b1, 8'h71);
      apb(`SPISC_OFS_DATA, 1'b1, 8'h1E);
      n = 0;
      while (pins.sckOut === 1'b0 && n < 100) begin
         @(posedge core_clk);
         n++;
      end
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pins.sckOut === 1'b1 && n < 100);
      chk8("halfPeriod", 8'h08, n[7:0]);
      wait_done();
      chk8("mosiLsb", 8'h78, far.slvRx);
      apb(`SPISC_OFS_DATA, 1'b0, 8'h00);
      chk8("rxLsb", 8'h6C, rdat[7:0]);
      apb(`SPISC_OFS_CTRL, 1'b1, 8'h58);
      chk1("sckIdleHigh", 1'b1, pins.sckOut);
      // Select pulled low mid-transfer while it is an input
      apb(`SPISC_OFS_CTRL, 1'b1, 8'hD0);
      apb(`SPISC_OFS_IMASK, 1'b1, 8'h02);
      apb(`SPISC_OFS_DATA, 1'b1, 8'hFF);
      repeat (6) @(posedge core_clk);
      far.set_ss(1'b0);
      repeat (4) @(posedge core_clk);
      chk1("irqFault", 1'b1, irq);
      chk8("faultOe", 8'h00, {6'h0, pins.sckOe, pins.mosiOe});
      apb(`SPISC_OFS_CTRL, 1'b0, 8'h00);
      chk8("ctrlFault", 8'hC0, rdat[7:0]);
      apb(`SPISC_OFS_ISTAT, 1'b0, 8'h00);
      chk1("faultEvent", 1'b1, rdat[1]);
      far.set_ss(1'b1);
      apb(`SPISC_OFS_ISTAT, 1'b1, 8'h03);
      apb(`SPISC_OFS_ISTAT, 1'b0, 8'h00);
      chk1("faultCleared", 1'b0, rdat[1]);
      wait_done();
      apb(`SPISC_OFS_DATA, 1'b0, 8'h00);
      apb(`SPISC_OFS_CTRL, 1'b1, 8'h50);
      apb(`SPISC_OFS_CTRL, 1'b0, 8'h00);
      chk8("masterAgain", 8'h50, rdat[7:0]);
      // Select as output is plain GPIO
      apb(`SPISC_OFS_PINS, 1'b1, 8'h8D);
      far.set_ss(1'b0);
      repeat (4) @(posedge core_clk);
      chk8("ssGpio", 8'h03, {6'h0, pins.ssOut, pins.ssOe});
      apb(`SPISC_OFS_CTRL, 1'b0, 8'h00);
      chk8("ctrlKept", 8'h50, rdat[7:0]);
      far.set_ss(1'b1);
      // Disabled port does nothing on a data write
      apb(`SPISC_OFS_CTRL, 1'b1, 8'h10);
      apb(`SPISC_OFS_PINS, 1'b1, 8'h05);
      apb(`SPISC_OFS_DATA, 1'b1, 8'h33);
      repeat (100) @(posedge core_clk);
      apb(`SPISC_OFS_STAT, 1'b0, 8'h00);
      chk8("noOp", 8'h00, rdat[7:0]);
      // Slave, deselected: all pins inputs, clocks ignored
      apb(`SPISC_OFS_PINS, 1'b1, 8'h0F);
      apb(`SPISC_OFS_CTRL, 1'b1, 8'h40);
      chk8("oeIdle", 8'h00, {4'h0, pins.mosiOe, pins.misoOe, pins.sckOe, pins.ssOe});
      far.xfer(8'hAA, 8, 1'b0);
      apb(`SPISC_OFS_STAT, 1'b0, 8'h00);
      chk8("ignored", 8'h00, rdat[7:0]);
      apb(`SPISC_OFS_DATA, 1'b1, 8'h5A);
      far.set_ss(1'b0);
      repeat (3) @(posedge core_clk);
      chk8("oeSel", 8'h04, {4'h0, pins.mosiOe, pins.misoOe, pins.sckOe, pins.ssOe});
      // Partial byte dropped by a select rise
      far.xfer(8'hFF, 3, 1'b1);
      far.xfer(8'hC3, 8, 1'b1);
      wait_done();
      chk8("misoByte", 8'h5A, far.mstRx);
      apb(`SPISC_OFS_DATA, 1'b0, 8'h00);
      chk8("slaveRx", 8'hC3, rdat[7:0]);
      print_verdict();
   end
endmodule
